/* rtl/adcc_top.sv */
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module adcc_top
   import adcc_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          arst_n,
   // avalon-mm slave
   input  wire logic [3:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   input  wire logic [3:0]    avs_byteenable,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest,
   output logic [1:0]         avs_response,
   // analog core side
   input  wire logic          cmpHigh,
   output logic               convPowerEn,
   output logic               convReset,
   output logic               convSample,
   output logic [4:0]         inputChannel,
   output logic               referenceSel,
   output logic [RES_W-1:0]   dacCode,
   output logic               convIrq
);
   import adcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum {S_IDLE, S_HOLD, S_CONV} adcc_state_t;

   typedef struct packed {
      adcc_state_t      state;      // sequencer state
      logic [7:0]       ctrl0;      // conv_control_0 (busy bit unused here)
      logic [7:0]       ctrl1;      // conv_control_1
      logic             gie;        // global_irq_enable
      logic             cie;        // conv_irq_enable
      logic             irqReq;     // conv_irq_request
      logic             busy;       // conv_busy_flag
      logic [4:0]       periods;    // converter clocks elapsed
      logic [RES_W-1:0] result;     // last completed value
      logic [31:0]      rdata;      // registered read data
      logic             ack;        // waitrequest low for one cycle
      logic [1:0]       resp;       // avalon response
      logic             irq;        // registered irq output
      logic             pwr;        // registered power enable
      logic             rst;        // registered converter reset
      logic             sample;     // registered sample strobe
   } adcc_st_t;

   adcc_st_t st_r, st_nxt;
   logic     tick;      // one converter clock period elapsed
   logic     sarInit;   // load sar with midscale
   logic     sarStep;   // decide one bit
   logic [RES_W-1:0] trial; // sar trial code
   logic [7:0] wbyte;   // byte-lane-masked write data

   ////////////////////////////////////////////////////////////////////////////
   // converter clock from system clock; restarted with each conversion
   adcc_clkdiv u_div (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .clear   (st_r.state != S_CONV),
      .divSel  (st_r.ctrl1[CTRL1_DIV_MSB:0]),
      .tick    (tick)
   );

   // binary search engine; comparator input assumed to embed half-step offset
   // the offset lives in the analog core, so the digital search stays plain binary
   adcc_sar u_sar (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .init    (sarInit),
      .step    (sarStep),
      .cmpHigh (cmpHigh),
      .trial   (trial)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one waitrequest cycle then answer
   // every request costs exactly two cycles: the first edge registers the
   // answer, the second edge (waitrequest low) is where a write lands.
   // a fixed latency keeps the slave simple; the price is one wait state
   // even for registers that could answer at once.
   // only byte lane 0 carries register bits; the upper lanes read as zero
   assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

   // read mux for the registered read data; the response comes from mapped()
   function automatic logic [31:0] readMux(input adcc_st_t s, input logic [3:0] a);
      logic [7:0] c0;
      c0 = s.ctrl0;
      c0[CTRL0_BUSY] = s.busy;
      c0[CTRL0_START] = s.ctrl0[CTRL0_START];
      unique case (a)
         ADDR_CTRL0:  readMux = {24'h000000, c0};
         ADDR_CTRL1:  readMux = {24'h000000, s.ctrl1};
         ADDR_RES_LO: readMux = {24'h000000, s.result[7:0]};
         ADDR_RES_HI: readMux = {28'h0000000, s.result[RES_W-1:8]};
         ADDR_IRQCTL: readMux = {29'h00000000, s.irqReq, s.cie, s.gie};
         default:     readMux = 32'h00000000;
      endcase
   endfunction

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a <= ADDR_IRQCTL);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // all next-state logic
   always_comb begin
      logic doWr;     // write takes effect this edge
      logic doRd;     // read completes this edge
      logic startNow; // falling edge of start seen
      logic finish;   // conversion done this cycle
      logic clrReq;   // software clearing request flag
      doWr     = 1'b0;
      doRd     = 1'b0;
      startNow = 1'b0;
      finish   = 1'b0;
      clrReq   = 1'b0;
      st_nxt   = st_r;
      sarInit  = 1'b0;
      sarStep  = 1'b0;
      st_nxt.ack = 1'b0;
      // request answered in the cycle after it is seen
      if ((avs_read || avs_write) && !st_r.ack) begin
         st_nxt.ack  = 1'b1;
         st_nxt.resp = mapped(avs_address) ? 2'b00 : 2'b10;
         st_nxt.rdata = avs_read ? readMux(st_r, avs_address) : 32'h00000000;
      end
      doWr = avs_write && st_r.ack;
      doRd = avs_read && st_r.ack;
      // register writes land at the edge where waitrequest is low
      if (doWr && avs_byteenable[0]) begin
         unique case (avs_address)
            ADDR_CTRL0: begin
               st_nxt.ctrl0 = wbyte;
               st_nxt.ctrl0[CTRL0_BUSY] = 1'b0;
               // start bit falling while powered on begins conversion
               if (st_r.ctrl0[CTRL0_START] && !wbyte[CTRL0_START]
                   && !st_r.ctrl0[CTRL0_PWROFF]) begin
                  startNow = 1'b1;
               end
            end
            ADDR_CTRL1: st_nxt.ctrl1 = wbyte;
            ADDR_IRQCTL: begin
               st_nxt.gie = wbyte[IRQ_GLOBAL];
               st_nxt.cie = wbyte[IRQ_CONV];
               clrReq     = !wbyte[IRQ_REQ];
            end
            default: ;
         endcase
      end
      // sequencer
      // idle -> hold while start is high (converter kept in reset), hold ->
      // conv when software drops start, conv -> idle after sixteen converter
      // clocks. a start pulse or power-off during conv aborts it; the last
      // completed result is never touched by an abort.
      // the processor is free during conv: nothing here waits on the bus.
      unique case (st_r.state)
         S_IDLE: begin
            // converter held in reset while start is high
            if (st_r.ctrl0[CTRL0_START] && !st_r.ctrl0[CTRL0_PWROFF]) begin
               st_nxt.state = S_HOLD;
            end
         end
         S_HOLD: begin
            if (st_r.ctrl0[CTRL0_PWROFF]) begin
               st_nxt.state = S_IDLE;
            end else if (startNow) begin
               st_nxt.state   = S_CONV;
               st_nxt.busy    = 1'b1;
               st_nxt.periods = '0;
               sarInit        = 1'b1;
            end
         end
         S_CONV: begin
            if (st_r.ctrl0[CTRL0_PWROFF]) begin
               st_nxt.state = S_IDLE; // power loss aborts, result kept
               st_nxt.busy  = 1'b0;
            end else if (st_r.ctrl0[CTRL0_START]) begin
               st_nxt.state = S_HOLD;
               st_nxt.busy  = 1'b0;
            end else if (tick) begin
               sarStep        = 1'b1;
               st_nxt.periods = st_r.periods + 5'h01;
               if (st_r.periods == CONV_PERIODS - 5'h01) begin
                  finish = 1'b1;
               end
            end
         end
         default: st_nxt.state = S_IDLE;
      endcase
      if (finish) begin
         st_nxt.state  = S_IDLE;
         st_nxt.busy   = 1'b0;
         st_nxt.result = trial;
      end
      // hardware set wins over software clear
      if (clrReq) begin
         st_nxt.irqReq = 1'b0;
      end
      if (finish) begin
         st_nxt.irqReq = 1'b1;
      end
      st_nxt.irq    = st_nxt.irqReq && st_nxt.gie && st_nxt.cie;
      st_nxt.pwr    = !st_nxt.ctrl0[CTRL0_PWROFF];
      st_nxt.rst    = st_nxt.state == S_HOLD;
      st_nxt.sample = sarInit;
      if (doRd) begin
         st_nxt.rdata = st_r.rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // single state register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r       <= '0;
         st_r.state <= S_IDLE;
         st_r.ctrl0 <= CTRL0_RST;
         st_r.ctrl1 <= CTRL1_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign avs_readdata    = st_r.rdata;
   assign avs_waitrequest = !st_r.ack;
   assign avs_response    = st_r.resp;
   assign convPowerEn     = st_r.pwr;
   assign convReset       = st_r.rst;
   assign convSample      = st_r.sample;
   assign inputChannel    = {st_r.ctrl1[CTRL1_CH4], st_r.ctrl0[CTRL0_CHLO_MSB:0]};
   assign referenceSel    = st_r.ctrl1[CTRL1_REFSEL];
   assign dacCode         = trial;
   assign convIrq         = st_r.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // each property watches one registered output or one piece of sequencer
   // state; they are kept next to the logic so a change to the sequencer
   // shows up here first. all share the system clock and the async reset.
   // properties that check a falling busy flag exclude the abort paths (power-off
   // and a new start pulse), because those also drop the busy flag.
   AST_BUSY_FALL_SETS_REQ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $fell(st_r.busy) && st_r.state == S_IDLE && !$past(st_r.ctrl0[CTRL0_PWROFF])
      && !$past(st_r.ctrl0[CTRL0_START]) |-> st_r.irqReq)
      else $error("request flag not set at completion");
   AST_IRQ_GATED: assert property (@(posedge clk_sys) disable iff (!arst_n)
      convIrq |-> st_r.gie && st_r.cie && st_r.irqReq)
      else $error("interrupt without both enables");
   AST_PWR_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r.ctrl0[CTRL0_PWROFF] |-> !convPowerEn)
      else $error("converter powered while off");
   AST_OFF_NO_START: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r.ctrl0[CTRL0_PWROFF] && st_r.state == S_IDLE |=> !st_r.busy)
      else $error("conversion started while powered off");
   AST_BUSY_IN_CONV: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r.busy == (st_r.state == S_CONV))
      else $error("busy flag disagrees with sequencer");
   AST_RESULT_HELD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !$past(st_r.busy) |-> $stable(st_r.result))
      else $error("result changed outside completion");
   AST_RESET_WHILE_START: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r.state == S_HOLD |-> convReset)
      else $error("converter not reset while start high");
   AST_PERIOD_LIMIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r.busy |-> st_r.periods < CONV_PERIODS)
      else $error("conversion exceeded sixteen periods");
   AST_CHANNEL: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !$past(avs_write && !avs_waitrequest) |-> $stable(inputChannel))
      else $error("channel select changed without a write");

   // the sample strobe marks the first cycle of a conversion only
   AST_SAMPLE_AT_START: assert property (@(posedge clk_sys) disable iff (!arst_n)
      convSample |-> st_r.busy && st_r.periods == '0)
      else $error("sample strobe outside conversion start");

   // converter reset only while the start bit holds the sequencer
   AST_NO_STRAY_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r.state != S_HOLD |-> !convReset)
      else $error("converter reset outside hold");

   // power enable follows the power-off bit in the same cycle
   AST_POWER_MATCH: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !st_r.ctrl0[CTRL0_PWROFF] |-> convPowerEn)
      else $error("converter unpowered while enabled");

   // reference choice only moves with a register write
   AST_REF_STABLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !$past(avs_write && !avs_waitrequest) |-> $stable(referenceSel))
      else $error("reference select changed without a write");

   // no request, no interrupt line
   AST_IRQ_NEEDS_REQ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !st_r.irqReq |-> !convIrq)
      else $error("interrupt without request");

   // a normal completion copies the final trial code into the result
   AST_FINISH_RESULT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $fell(st_r.busy) && st_r.state == S_IDLE && !$past(st_r.ctrl0[CTRL0_PWROFF])
      && !$past(st_r.ctrl0[CTRL0_START]) |-> st_r.result == $past(trial))
      else $error("result not taken from search at completion");

   // waitrequest is low for one cycle per request
   AST_WAIT_ONE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   // the undefined divider code freezes the converter clock
   AST_NO_TICK_UNDEF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r.ctrl1[CTRL1_DIV_MSB:0] == DIV_UNDEF
      && $past(st_r.ctrl1[CTRL1_DIV_MSB:0]) == DIV_UNDEF |-> !tick)
      else $error("converter clock ran on the undefined code");
endmodule

/* rtl/adcc_pkg.sv */
package adcc_pkg;
   // avalon word addresses (byte address = 4 * index)
   localparam logic [3:0] ADDR_CTRL0   = 4'h0;  // conv_control_0
   localparam logic [3:0] ADDR_CTRL1   = 4'h1;  // conv_control_1
   localparam logic [3:0] ADDR_RES_LO  = 4'h2;  // result low byte
   localparam logic [3:0] ADDR_RES_HI  = 4'h3;  // result high nibble
   localparam logic [3:0] ADDR_IRQCTL  = 4'h4;  // irq enables and request
   // conv_control_0 fields
   localparam int CTRL0_START    = 7;
   localparam int CTRL0_BUSY     = 6;
   localparam int CTRL0_PWROFF   = 5;
   localparam int CTRL0_CHLO_MSB = 3;          // channel bits 3..0
   // conv_control_1 fields
   localparam int CTRL1_CH4      = 7;          // channel bit 4
   localparam int CTRL1_REFSEL   = 6;
   localparam int CTRL1_DIV_MSB  = 2;          // divider bits 2..0
   // irq control fields
   localparam int IRQ_GLOBAL     = 0;
   localparam int IRQ_CONV       = 1;
   localparam int IRQ_REQ        = 2;
   // reset values
   localparam logic [7:0] CTRL0_RST = 8'h20;   // powered off
   localparam logic [7:0] CTRL1_RST = 8'h00;
   // timing
   localparam logic [4:0] CONV_PERIODS = 5'h10; // converter clocks per conversion
   localparam logic [2:0] DIV_UNDEF    = 3'h7;
   localparam logic [5:0] MAX_PRESCALE = 6'h3f;
   localparam int RES_W = 12;
endpackage

/* rtl/adcc_clkdiv.sv */
`timescale 1ns/10ps
// converter clock enable generator
module adcc_clkdiv
   import adcc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       clear,
   input  wire logic [2:0] divSel,
   output logic            tick
);
   typedef struct packed {
      logic [5:0] cnt;  // prescale counter
      logic       tick; // one cycle per converter clock period
   } adcc_div_t;
   adcc_div_t st_r, st_nxt;

   // divider limit: 2^code - 1; undefined code freezes the clock
   function automatic logic [5:0] divLimit(input logic [2:0] c);
      divLimit = MAX_PRESCALE >> (3'h6 - c);
   endfunction

   // count and wrap
   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (clear) begin
         st_nxt.cnt = '0;
      end else if (divSel != DIV_UNDEF) begin
         if (st_r.cnt >= divLimit(divSel)) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;
endmodule

/* rtl/adcc_sar.sv */
`timescale 1ns/10ps
// successive approximation register: one bit decided per step
module adcc_sar
   import adcc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             init,
   input  wire logic             step,
   input  wire logic             cmpHigh,
   output logic [RES_W-1:0]      trial
);
   typedef struct packed {
      logic [RES_W-1:0] val;  // current trial code
      logic [RES_W-1:0] bitm; // bit under test
   } adcc_sar_t;
   adcc_sar_t st_r, st_nxt;

   // msb-first binary search
   always_comb begin
      st_nxt = st_r;
      if (init) begin
         st_nxt.bitm = {1'b1, {(RES_W-1){1'b0}}};
         st_nxt.val  = {1'b1, {(RES_W-1){1'b0}}};
      end else if (step && st_r.bitm != '0) begin
         if (!cmpHigh) begin
            st_nxt.val = st_r.val & ~st_r.bitm; // input below trial, drop bit
         end
         st_nxt.bitm = st_r.bitm >> 1;
         st_nxt.val  = st_nxt.val | (st_r.bitm >> 1);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign trial = st_r.val;
endmodule

/* test/adcc_analog_model.sv */
`timescale 1ns/10ps
// behavioural converter core: comparator against the trial code of the sar
module adcc_analog_model #(
   parameter longint REF_PIN_MV = 2048,     // level on the reference pin
   parameter longint SUPPLY_MV  = 4096      // positive supply level
) (
   input  wire logic        clk_sys,
   input  wire logic        convPowerEn,
   input  wire logic        referenceSel,
   input  wire logic [4:0]  inputChannel,
   input  wire logic [11:0] dacCode,
   input  wire logic [12:0] level,
   input  wire logic [4:0]  levelChan,
   output logic             cmpHigh
);
   ////////////////////////////////////////////////////////////////////////////////
   logic   toggle_r = 1'b0;                 // junk pattern while unpowered
   longint vinMv;                           // level on the selected channel
   longint vrefMv;                          // selected reference level

   // an unpowered comparator gives nothing trustworthy, so keep it moving
   always @(posedge clk_sys) begin
      toggle_r <= ~toggle_r;
   end

   // ideal comparator with the half-step offset built in
   always_comb begin
      vrefMv = referenceSel ? REF_PIN_MV : SUPPLY_MV;
      vinMv  = (inputChannel == levelChan) ? longint'(level) : 0;
      if (!convPowerEn) begin
         cmpHigh = toggle_r;
      end else if (dacCode == 12'h000) begin
         cmpHigh = 1'b1;
      end else begin
         // transition for code k sits at (k - 0.5) steps of vref/4096
         cmpHigh = (vinMv * 8192) >= ((2 * longint'(dacCode) - 1) * vrefMv);
      end
   end
endmodule

/* test/adc_conversion_control_tb.sv */
`timescale 1ns/10ps
module adc_conversion_control_tb;
   import adcc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic          clk_sys         = 1'b0;
   logic          arst_n          = 1'b0;
   logic [3:0]    avs_address     = 4'h0;
   logic          avs_read        = 1'b0;
   logic          avs_write       = 1'b0;
   logic [31:0]   avs_writedata   = 32'h0;
   logic [3:0]    avs_byteenable  = 4'h0;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [1:0]    avs_response;
   logic          cmpHigh;
   logic          convPowerEn;
   logic          convReset;
   logic          convSample;
   logic [4:0]    inputChannel;
   logic          referenceSel;
   logic [11:0]   dacCode;
   logic          convIrq;
   logic [12:0]   level           = 13'h0;   // analog level in mV
   logic [4:0]    levelChan       = 5'h0;    // channel carrying that level
   logic [31:0]   rdat;
   logic [1:0]    resp;
   logic [11:0]   lastCode;                  // last completed result
   int            mismatches      = 0;
   int            samples_checked = 0;

   always #5 clk_sys = ~clk_sys;

   adcc_top i_adcc_top (
      .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .cmpHigh(cmpHigh), .convPowerEn(convPowerEn), .convReset(convReset),
      .convSample(convSample), .inputChannel(inputChannel),
      .referenceSel(referenceSel), .dacCode(dacCode), .convIrq(convIrq));

   adcc_analog_model i_adcc_analog_model (
      .clk_sys(clk_sys), .convPowerEn(convPowerEn), .referenceSel(referenceSel),
      .inputChannel(inputChannel), .dacCode(dacCode), .level(level),
      .levelChan(levelChan), .cmpHigh(cmpHigh));

   ////////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one avalon transfer; held until waitrequest is sampled low, then an idle edge
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= 4'hf;
      avs_write      <= wr;
      avs_read       <= ~wr;
      @(posedge clk_sys);
      // no cycle limit here: the watchdog ends a hung request
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      rdat = avs_readdata;
      resp = avs_response;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd12(output logic [11:0] code);
      logic [7:0] lo;
      xfer(1'b0, ADDR_RES_LO, 32'h0);
      lo = rdat[7:0];
      xfer(1'b0, ADDR_RES_HI, 32'h0);
      code = {rdat[3:0], lo};
   endtask

   // expected code from the ideal transfer curve, saturating at full scale
   function automatic logic [11:0] expc(input logic refPin, input int mv);
      int c;
      c = refPin ? 2 * mv : mv;
      return (c > 4095) ? 12'hfff : c[11:0];
   endfunction

   // full conversion: setup, start pulse, idle wait, poll, result and irq
   task automatic conv(input logic [4:0] ch, input logic rs, input logic [2:0] dv,
                       input int mv, input logic [1:0] irqEn);
      int n;
      logic [11:0] code;
      n = 16 << dv;
      level     <= mv[12:0];
      levelChan <= ch;
      xfer(1'b1, ADDR_CTRL1, {24'h0, ch[4], rs, 3'b000, dv});
      xfer(1'b1, ADDR_CTRL0, {24'h0, 4'h8, ch[3:0]});
      // hold state is entered one edge after the write lands
      @(posedge clk_sys);
      check(convReset, 1'b1);
      xfer(1'b1, ADDR_CTRL0, {24'h0, 4'h0, ch[3:0]});
      xfer(1'b1, ADDR_IRQCTL, {29'h0, 1'b0, irqEn});
      repeat (n - (1 << dv) - 7) @(posedge clk_sys);
      xfer(1'b0, ADDR_CTRL0, 32'h0);
      check(rdat[7:0], {4'h4, ch[3:0]});
      repeat ((1 << dv) + 10) @(posedge clk_sys);
      xfer(1'b0, ADDR_CTRL0, 32'h0);
      check(rdat[7:0], {4'h0, ch[3:0]});
      check(inputChannel, ch);
      check(referenceSel, rs);
      rd12(code);
      check(code, expc(rs, mv));
      lastCode = code;
      xfer(1'b0, ADDR_IRQCTL, 32'h0);
      check(rdat[2:0], {1'b1, irqEn});
      check(convIrq, &irqEn);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard, well past the longest expected run
   initial begin
      repeat (30000) @(posedge clk_sys);
      mismatches++;
      summarize();
   end

   // main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      check(convPowerEn, 1'b0);
      xfer(1'b0, ADDR_CTRL0, 32'h0);
      check(rdat, {24'h0, CTRL0_RST});
      xfer(1'b0, ADDR_CTRL1, 32'h0);
      check(rdat, 32'h0);
      xfer(1'b0, 4'h5, 32'h0);
      check(rdat, 32'h0);
      check(resp, 2'b10);
      // power on first, as the setup order asks
      xfer(1'b1, ADDR_CTRL0, 32'h0);
      check(convPowerEn, 1'b1);
      // every defined divider, both references, spread of channels
      for (int d = 0; d < 7; d++) begin
         conv(5'(d * 5), d[0], d[2:0], 300 + d * 500, (d == 0) ? 2'b11 : (d == 1) ? 2'b10 : 2'b00);
      end
      conv(5'h1f, 1'b0, 3'h0, 4096, 2'b00);
      // clearing the request keeps the line low with both enables set
      xfer(1'b1, ADDR_IRQCTL, 32'h3);
      check(convIrq, 1'b0);
      // restart mid conversion: aborted, result kept, then a fresh one runs
      level <= 13'd1234;
      xfer(1'b1, ADDR_CTRL1, 32'h06);
      xfer(1'b1, ADDR_CTRL0, 32'h8f);
      xfer(1'b1, ADDR_CTRL0, 32'h0f);
      repeat (100) @(posedge clk_sys);
      xfer(1'b1, ADDR_CTRL0, 32'h8f);
      xfer(1'b0, ADDR_CTRL0, 32'h0);
      check(rdat[7:0], 8'h8f);
      rd12(rdat[11:0]);
      check(rdat[11:0], lastCode);
      conv(5'h1f, 1'b0, 3'h2, 1234, 2'b00);
      // start while powered off does nothing
      xfer(1'b1, ADDR_CTRL0, 32'h20);
      check(convPowerEn, 1'b0);
      xfer(1'b1, ADDR_CTRL0, 32'ha0);
      xfer(1'b1, ADDR_CTRL0, 32'h20);
      repeat (40) @(posedge clk_sys);
      xfer(1'b0, ADDR_CTRL0, 32'h0);
      check(rdat[7:0], 8'h20);
      rd12(rdat[11:0]);
      check(rdat[11:0], lastCode);
      summarize();
   end
endmodule
